// >>> design/rcwd_pkg.sv
// Shared constants for the reset-cause and watchdog block.
// Assumes a single 25 MHz system clock; no other files are needed.
package rcwd_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  // power_on_delay, 10 us, least time so rounded up
  localparam int unsigned POR_DELAY_NS = 10_000;
  localparam int unsigned POR_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // monitor_settle_delay, 100 us
  localparam int unsigned MON_DELAY_NS = 100_000;
  localparam int unsigned MON_CYC = (MON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // powerup_timer_delay choices, in ms
  localparam int unsigned POWERUP_TIMER_A_MS = 4;
  localparam int unsigned POWERUP_TIMER_B_MS = 16;
  localparam int unsigned POWERUP_TIMER_C_MS = 64;
  localparam int unsigned NS_PER_MS = 1_000_000;
  localparam int unsigned POWERUP_TIMER_A_CYC_DEF = POWERUP_TIMER_A_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_TIMER_B_CYC_DEF = POWERUP_TIMER_B_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_TIMER_C_CYC_DEF = POWERUP_TIMER_C_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W = 21;
  localparam int unsigned SHORT_HOLD_CYC = 1;

  // powerup_timer selection codes
  localparam logic [1:0] POWERUP_TIMER_NONE = 2'h0;
  localparam logic [1:0] POWERUP_TIMER_A = 2'h1;
  localparam logic [1:0] POWERUP_TIMER_B = 2'h2;

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] RCS_OFF = 4'h0;
  localparam logic [ADDR_W-1:0] WDC_OFF = 4'h1;

  // reset_control_status field positions
  localparam int unsigned TRAP_BIT = 15;
  localparam int unsigned IOP_BIT = 14;
  localparam int unsigned EXT_BIT = 7;
  localparam int unsigned SWR_BIT = 6;
  localparam int unsigned WATCHDOG_SOFT_ENABLE_BIT = 5;
  localparam int unsigned WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int unsigned SLEEP_BIT = 3;
  localparam int unsigned IDLE_BIT = 2;
  localparam int unsigned BOR_BIT = 1;
  localparam int unsigned POR_BIT = 0;
  localparam logic [DATA_W-1:0] RCS_RST = 16'h0003;
  localparam logic [DATA_W-1:0] RCS_MASK = 16'hc0ff;

  // ------------------------------------------------------------
  // Program counter
  // ------------------------------------------------------------
  localparam int unsigned PC_W = 24;
  localparam logic [PC_W-1:0] RESET_VEC = 24'h000000;
  localparam logic [PC_W-1:0] CLKFAIL_VEC = 24'h000004;
  localparam logic [PC_W-1:0] PC_STEP = 24'h000002;

  // ------------------------------------------------------------
  // Watchdog and control state
  // ------------------------------------------------------------
  localparam int unsigned WDT_W_DEF = 16;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN = 2'b10
  } rcwd_state_t;

endpackage : rcwd_pkg

// >>> design/rcwd_top.sv
// Reset-cause recorder, internal reset stretcher and watchdog controller.
// Assumes every event input is a one-cycle pulse synchronous to mclk_i, that
// sleep_i and idle_i are levels from the power-saving logic, and that the
// brown-out comparator and pin filter live outside.
`timescale 1ns/1ns
module rcwd_top import rcwd_pkg::*; #(
  parameter int unsigned POWERUP_TIMER_A_CYC = POWERUP_TIMER_A_CYC_DEF,
  parameter int unsigned POWERUP_TIMER_B_CYC = POWERUP_TIMER_B_CYC_DEF,
  parameter int unsigned POWERUP_TIMER_C_CYC = POWERUP_TIMER_C_CYC_DEF,
  parameter int unsigned WDT_W = WDT_W_DEF
) (
  // Clock and reset
  input logic mclk_i,
  input logic rst_i,
  // Register port
  input logic [ADDR_W-1:0] addr_i,
  input logic [DATA_W-1:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // Reset and wake causes
  input logic por_evt_i,
  input logic bor_detect_i,
  input logic master_clear_pin_i,
  input logic reset_instr_i,
  input logic trap_conflict_i,
  input logic illegal_op_i,
  input logic clk_fail_i,
  input logic irq_wake_i,
  input logic [PC_W-1:0] irq_vector_i,
  // Processor state
  input logic [PC_W-1:0] cur_pc_i,
  input logic sleep_i,
  input logic idle_i,
  input logic watchdog_clear_instr_i,
  input logic rc_tick_i,
  // Configuration
  input logic watchdog_fuse_enable_i,
  input logic bor_enable_i,
  input logic [1:0] powerup_timer_sel_i,
  input logic xtal_osc_i,
  // Reset and restart
  output logic sys_rst_o,
  output logic restart_o,
  output logic [PC_W-1:0] restart_pc_o,
  output logic wake_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // concurrent delay choice
  function automatic logic [HOLD_W-1:0] hold_cycles(input logic [1:0] sel,
                                                    input logic xtal);
    logic [HOLD_W-1:0] powerup_timer;
    powerup_timer = HOLD_W'(POWERUP_TIMER_C_CYC);
    if (sel == POWERUP_TIMER_A) begin
      powerup_timer = HOLD_W'(POWERUP_TIMER_A_CYC);
    end else if (sel == POWERUP_TIMER_B) begin
      powerup_timer = HOLD_W'(POWERUP_TIMER_B_CYC);
    end
    if (sel == POWERUP_TIMER_NONE) begin
      return xtal ? HOLD_W'(POR_CYC + MON_CYC) : HOLD_W'(POR_CYC);
    end
    return (powerup_timer > HOLD_W'(POR_CYC)) ? powerup_timer : HOLD_W'(POR_CYC);
  endfunction : hold_cycles

  function automatic logic [PC_W-1:0] pc_next(input logic [PC_W-1:0] pc);
    return pc + PC_STEP;
  endfunction : pc_next

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  rcwd_state_t state_q;
  rcwd_state_t state_d;
  logic [DATA_W-1:0] rcs_q;
  logic [DATA_W-1:0] rcs_d;
  logic [DATA_W-1:0] rcs_base;
  logic [HOLD_W-1:0] hold_cnt_q;
  logic [HOLD_W-1:0] hold_tgt_q;
  logic [HOLD_W-1:0] tgt_d;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic restart_q;
  logic wake_q;
  logic [DATA_W-1:0] rdata_q;
  logic evt_hold;
  logic evt_go;
  logic evt_wake;
  logic bor_hit;
  logic running;
  logic hold_done;
  logic wdt_en;
  logic wdt_ovf;
  logic [WDT_W-1:0] wdt_count;

  assign running = (state_q == ST_RUN);
  assign hold_done = (hold_cnt_q >= hold_tgt_q);
  assign bor_hit = bor_enable_i && bor_detect_i;

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  // fuse forces enable
  assign wdt_en = running && (watchdog_fuse_enable_i || rcs_q[WATCHDOG_SOFT_ENABLE_BIT]);

  rcwd_wdog #(
    .WIDTH(WDT_W)
  ) u_wdog (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .en_i(wdt_en),
    .tick_i(rc_tick_i),
    .clear_i(watchdog_clear_instr_i || !running),
    .overflow_o(wdt_ovf),
    .count_o(wdt_count)
  );

  // ------------------------------------------------------------
  // Cause decoding
  // ------------------------------------------------------------
  // software write first
  assign rcs_base = (wr_i && addr_i == RCS_OFF) ? (wdata_i & RCS_MASK) : rcs_q;

  // Events are applied on top of a same-cycle write, so a cause is never lost to a write.
  always_comb begin
    rcs_d = rcs_base;
    pc_d = pc_q;
    tgt_d = HOLD_W'(SHORT_HOLD_CYC);
    evt_hold = 1'b0;
    evt_go = 1'b0;
    evt_wake = 1'b0;
    if (por_evt_i) begin
      rcs_d = RCS_RST;
      pc_d = RESET_VEC;
      tgt_d = hold_cycles(powerup_timer_sel_i, xtal_osc_i);
      evt_hold = 1'b1;
    end else if (bor_hit) begin
      rcs_d[BOR_BIT] = 1'b1;
      rcs_d[POR_BIT] = 1'b0;
      pc_d = RESET_VEC;
      tgt_d = hold_cycles(powerup_timer_sel_i, xtal_osc_i);
      evt_hold = 1'b1;
    end else if (running) begin
      if (master_clear_pin_i) begin
        rcs_d[EXT_BIT] = 1'b1;
        rcs_d[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
        if (sleep_i) begin
          rcs_d[SLEEP_BIT] = 1'b1;
          rcs_d[IDLE_BIT] = 1'b0;
        end else if (idle_i) begin
          rcs_d[IDLE_BIT] = 1'b1;
          rcs_d[SLEEP_BIT] = 1'b0;
        end else begin
          rcs_d[SWR_BIT] = 1'b0;
          rcs_d[IDLE_BIT] = 1'b0;
          rcs_d[SLEEP_BIT] = 1'b0;
        end
        pc_d = RESET_VEC;
        evt_hold = 1'b1;
      end else if (wdt_ovf && sleep_i) begin
        rcs_d[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
        rcs_d[SLEEP_BIT] = 1'b1;
        pc_d = pc_next(cur_pc_i);
        evt_go = 1'b1;
        evt_wake = 1'b1;
      end else if (wdt_ovf && idle_i) begin
        rcs_d[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
        rcs_d[IDLE_BIT] = 1'b1;
        pc_d = pc_next(cur_pc_i);
        evt_go = 1'b1;
        evt_wake = 1'b1;
      end else if (wdt_ovf) begin
        rcs_d[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
        rcs_d[EXT_BIT] = 1'b0;
        rcs_d[SWR_BIT] = 1'b0;
        rcs_d[IDLE_BIT] = 1'b0;
        rcs_d[SLEEP_BIT] = 1'b0;
        pc_d = RESET_VEC;
        evt_hold = 1'b1;
      end else if (trap_conflict_i) begin
        rcs_d[TRAP_BIT] = 1'b1;
        pc_d = RESET_VEC;
        evt_hold = 1'b1;
      end else if (illegal_op_i) begin
        rcs_d[IOP_BIT] = 1'b1;
        pc_d = RESET_VEC;
        evt_hold = 1'b1;
      end else if (reset_instr_i) begin
        rcs_d[SWR_BIT] = 1'b1;
        rcs_d[EXT_BIT] = 1'b0;
        rcs_d[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
        rcs_d[IDLE_BIT] = 1'b0;
        rcs_d[SLEEP_BIT] = 1'b0;
        pc_d = RESET_VEC;
        evt_hold = 1'b1;
      end else if (clk_fail_i) begin
        pc_d = CLKFAIL_VEC;
        evt_go = 1'b1;
      end else if (irq_wake_i && (sleep_i || idle_i)) begin
        if (sleep_i) begin
          rcs_d[SLEEP_BIT] = 1'b1;
        end else begin
          rcs_d[IDLE_BIT] = 1'b1;
        end
        pc_d = irq_vector_i;
        evt_go = 1'b1;
        evt_wake = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Reset state machine
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (!evt_hold && hold_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (evt_hold) begin
          state_d = ST_HOLD;
        end
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hold_cnt_q <= '0;
      hold_tgt_q <= hold_cycles(powerup_timer_sel_i, xtal_osc_i);
    end else if (evt_hold) begin
      hold_cnt_q <= '0;
      hold_tgt_q <= tgt_d;
    end else if (!running && !hold_done) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Status register and restart
  // ------------------------------------------------------------
  // named flag positions
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rcs_q <= RCS_RST;
    end else begin
      rcs_q <= rcs_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pc_q <= RESET_VEC;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Restart pulses when a hold ends or when a wake or trap redirects the core.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      restart_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      restart_q <= evt_go || (state_q == ST_HOLD && state_d == ST_RUN);
      wake_q <= evt_wake;
    end
  end

  assign sys_rst_o = (state_q == ST_HOLD);
  assign restart_o = restart_q;
  assign restart_pc_o = pc_q;
  assign wake_o = wake_q;

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  // Read data lasts one cycle; unmapped offsets read zero.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (rd_i && addr_i == RCS_OFF) begin
      rdata_q <= rcs_q;
    end else if (rd_i && addr_i == WDC_OFF) begin
      rdata_q <= DATA_W'(wdt_count);
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata_o = rdata_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_por_flags: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    por_evt_i |=> rcs_q == RCS_RST && pc_q == RESET_VEC && sys_rst_o)
    else $error("power-on did not load reset values");

  chk_bor_flags: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!por_evt_i && bor_hit) |=> rcs_q[BOR_BIT] && !rcs_q[POR_BIT] && sys_rst_o
    && rcs_q[TRAP_BIT] == $past(rcs_base[TRAP_BIT]))
    else $error("brown-out flags wrong");

  chk_hold_stretch: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!running && !hold_done) |=> sys_rst_o)
    else $error("reset released before delays elapsed");

  chk_monitor_delay: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (por_evt_i && powerup_timer_sel_i == POWERUP_TIMER_NONE && xtal_osc_i)
    |=> hold_tgt_q == HOLD_W'(POR_CYC + MON_CYC))
    else $error("crystal monitor delay not applied");

  chk_pin_reset: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (running && !por_evt_i && !bor_hit && master_clear_pin_i && !sleep_i && !idle_i)
    |=> rcs_q[EXT_BIT] && !rcs_q[SWR_BIT] && !rcs_q[WATCHDOG_TIMEOUT_FLAG_BIT] ##1 sys_rst_o)
    else $error("pin reset flags wrong");

  chk_wdt_reset: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (running && !por_evt_i && !bor_hit && !master_clear_pin_i && wdt_ovf
    && !sleep_i && !idle_i) |=> rcs_q[WATCHDOG_TIMEOUT_FLAG_BIT] && !rcs_q[EXT_BIT] && sys_rst_o)
    else $error("watchdog reset flags wrong");

  chk_wdt_wake: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (running && !por_evt_i && !bor_hit && !master_clear_pin_i && wdt_ovf && sleep_i)
    |=> restart_o && wake_o && restart_pc_o == pc_next($past(cur_pc_i))
    && rcs_q[WATCHDOG_TIMEOUT_FLAG_BIT] && rcs_q[SLEEP_BIT] && !sys_rst_o)
    else $error("watchdog wake from sleep wrong");

  chk_clk_fail: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (running && clk_fail_i && !wr_i && !por_evt_i && !bor_hit && !master_clear_pin_i
    && !wdt_ovf && !trap_conflict_i && !illegal_op_i && !reset_instr_i)
    |=> restart_pc_o == CLKFAIL_VEC && $stable(rcs_q) && restart_o)
    else $error("clock fail trap wrong");

  chk_brownout_any: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    bor_hit |=> sys_rst_o [*2])
    else $error("brown-out did not hold reset");

endmodule : rcwd_top

// >>> design/rcwd_wdog.sv
// Free-running watchdog counter advanced by watchdog oscillator ticks.
// Assumes tick_i is a one-cycle pulse per oscillator period, synchronous to mclk_i.
`timescale 1ns/1ns
module rcwd_wdog import rcwd_pkg::*; #(
  parameter int unsigned WIDTH = WDT_W_DEF
) (
  // Clock and reset
  input logic mclk_i,
  input logic rst_i,
  // Control
  input logic en_i,
  input logic tick_i,
  input logic clear_i,
  // Status
  output logic overflow_o,
  output logic [WIDTH-1:0] count_o
);

  logic [WIDTH-1:0] cnt_q;
  logic ovf_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i || clear_i) begin
      cnt_q <= '0;
    end else if (en_i && tick_i) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || clear_i) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= en_i && tick_i && (&cnt_q);
    end
  end

  assign overflow_o = ovf_q;
  assign count_o = cnt_q;

  chk_clear_zeroes: assert property (
    @(posedge mclk_i) disable iff (rst_i) clear_i |=> (cnt_q == '0) && !ovf_q)
    else $error("watchdog count not zero after clear");

  chk_disabled_holds: assert property (
    @(posedge mclk_i) disable iff (rst_i) (!en_i && !clear_i) |=> $stable(cnt_q) && !ovf_q)
    else $error("watchdog moved while disabled");

endmodule : rcwd_wdog

// >>> dv/rcwd_top_tb.sv
// Self-checking bench for the reset-cause recorder and watchdog top.
// Assumes rcwd_pkg is compiled first; hold counts are shortened by parameter.
`timescale 1ns/1ns
module rcwd_top_tb import rcwd_pkg::*;;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = 4'h0;
  logic [DATA_W-1:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic [8:0] ev = 9'h000;
  logic sleep_i = 1'b0;
  logic idle_i = 1'b0;
  logic rc_tick_i = 1'b0;
  logic fuse = 1'b1;
  logic [1:0] powerup_timer_sel = 2'h1;
  logic xtal = 1'b0;
  logic bor_en = 1'b1;
  logic [PC_W-1:0] irq_vec = 24'h000124;
  logic [PC_W-1:0] cur_pc = 24'h000100;
  logic sys_rst_o;
  logic restart_o;
  logic [PC_W-1:0] restart_pc_o;
  logic wake_o;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;

  always #20 mclk_i = ~mclk_i;

  rcwd_top #(.POWERUP_TIMER_A_CYC(300), .POWERUP_TIMER_B_CYC(600), .POWERUP_TIMER_C_CYC(900), .WDT_W(4)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .por_evt_i(ev[0]), .bor_detect_i(ev[1]),
    .master_clear_pin_i(ev[2]), .reset_instr_i(ev[3]), .trap_conflict_i(ev[4]),
    .illegal_op_i(ev[5]), .clk_fail_i(ev[6]), .irq_wake_i(ev[7]),
    .irq_vector_i(irq_vec), .cur_pc_i(cur_pc), .sleep_i(sleep_i), .idle_i(idle_i),
    .watchdog_clear_instr_i(ev[8]), .rc_tick_i(rc_tick_i),
    .watchdog_fuse_enable_i(fuse), .bor_enable_i(bor_en), .powerup_timer_sel_i(powerup_timer_sel),
    .xtal_osc_i(xtal), .sys_rst_o(sys_rst_o), .restart_o(restart_o),
    .restart_pc_o(restart_pc_o), .wake_o(wake_o));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      rc_tick_i <= 1'b1;
      @(posedge mclk_i);
      rc_tick_i <= 1'b0;
    end
  endtask : ticks

  task automatic pulse(input int e);
    @(posedge mclk_i);
    ev <= 9'h001 << e;
    @(posedge mclk_i);
    ev <= 9'h000;
  endtask : pulse

  // ------------------------------------------------------------
  // One cause: preset flags, fire it, then judge flags, restart address, hold
  // ------------------------------------------------------------
  // Event 9 stands for a watchdog overflow made of 16 oscillator ticks
  task automatic run_case(input int e, input logic s, input logic i, input logic [15:0] pre,
                          input logic [15:0] exp, input logic [23:0] pc, input int hmin,
                          input logic [1:0] rw);
    int hc;
    int n;
    int rs;
    int wk;
    logic [15:0] d;
    wr(RCS_OFF, pre);
    @(posedge mclk_i);
    sleep_i <= s;
    idle_i <= i;
    if (e < 9) begin
      pulse(e);
    end else begin
      ticks(16);
    end
    hc = 0;
    n = 0;
    rs = 0;
    wk = 0;
    while (n < 4000 && (n < 4 || sys_rst_o === 1'b1)) begin
      #1;
      if (sys_rst_o === 1'b1) hc++;
      if (restart_o === 1'b1) rs++;
      if (wake_o === 1'b1) wk++;
      @(posedge mclk_i);
      n++;
    end
    sleep_i <= 1'b0;
    idle_i <= 1'b0;
    rd(RCS_OFF, d);
    check({8'h00, d}, {8'h00, exp});
    check(restart_pc_o, pc);
    check(24'(rs), {23'h0, rw[1]});
    check(24'(wk), {23'h0, rw[0]});
    if (hmin > 0) begin
      check({23'h0, hc >= hmin && hc <= hmin + 3}, 24'h000001);
    end
  endtask : run_case

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic regs_rw;
    logic [15:0] d;
    wr(RCS_OFF, 16'hc0ff);
    rd(RCS_OFF, d);
    check({8'h00, d}, 24'h00c0ff);
    wr(RCS_OFF, 16'h0000);
    rd(RCS_OFF, d);
    check({8'h00, d}, 24'h000000);
    wr(4'h7, 16'hffff);
    rd(4'h7, d);
    check({8'h00, d}, 24'h000000);
  endtask : regs_rw

  task automatic wdog_enable_clear;
    logic [15:0] d;
    fuse <= 1'b0;
    wr(RCS_OFF, 16'h0000);
    ticks(20);
    rd(WDC_OFF, d);
    check({8'h00, d}, 24'h000000);
    check({23'h0, sys_rst_o}, 24'h000000);
    run_case(9, 1'b0, 1'b0, 16'h0020, 16'h0030, 24'h000000, 0, 2'h2);
    fuse <= 1'b1;
    // Soft enable off, so only the fuse can keep the count moving
    wr(RCS_OFF, 16'h0000);
    ticks(10);
    pulse(8);
    rd(WDC_OFF, d);
    check({8'h00, d}, 24'h000000);
    ticks(15);
    rd(WDC_OFF, d);
    check({8'h00, d}, 24'h00000f);
    check({23'h0, sys_rst_o}, 24'h000000);
  endtask : wdog_enable_clear

  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    logic [15:0] d;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    while (sys_rst_o !== 1'b0 && cyc < 2000) @(posedge mclk_i);
    check({23'h0, sys_rst_o}, 24'h000000);
    rd(RCS_OFF, d);
    check({8'h00, d}, 24'h000003);
    regs_rw();
    run_case(2, 1'b0, 1'b0, 16'hc0ff, 16'hc0a3, 24'h000000, 0, 2'h2);
    run_case(3, 1'b0, 1'b0, 16'hc0ff, 16'hc063, 24'h000000, 0, 2'h2);
    run_case(2, 1'b1, 1'b0, 16'hc0ff, 16'hc0eb, 24'h000000, 0, 2'h2);
    run_case(2, 1'b0, 1'b1, 16'hc0ff, 16'hc0e7, 24'h000000, 0, 2'h2);
    run_case(4, 1'b0, 1'b0, 16'h40ff, 16'hc0ff, 24'h000000, 0, 2'h2);
    run_case(5, 1'b0, 1'b0, 16'h80ff, 16'hc0ff, 24'h000000, 0, 2'h2);
    run_case(6, 1'b0, 1'b0, 16'hc0ff, 16'hc0ff, 24'h000004, 0, 2'h2);
    // Brown-out detection disabled: no reset, flags and vector untouched
    bor_en <= 1'b0;
    run_case(1, 1'b0, 1'b0, 16'hc0fd, 16'hc0fd, 24'h000004, 0, 2'h0);
    bor_en <= 1'b1;
    irq_vec <= 24'h000130;
    run_case(7, 1'b1, 1'b0, 16'h0000, 16'h0008, 24'h000130, 0, 2'h3);
    run_case(1, 1'b1, 1'b0, 16'hc0fd, 16'hc0fe, 24'h000000, 300, 2'h2);
    run_case(9, 1'b0, 1'b0, 16'hc0ec, 16'hc030, 24'h000000, 0, 2'h2);
    run_case(9, 1'b1, 1'b0, 16'h0000, 16'h0018, 24'h000102, 0, 2'h3);
    cur_pc <= 24'h000200;
    run_case(9, 1'b0, 1'b1, 16'h0000, 16'h0014, 24'h000202, 0, 2'h3);
    powerup_timer_sel <= 2'h2;
    run_case(0, 1'b0, 1'b0, 16'hc0fc, 16'h0003, 24'h000000, 600, 2'h2);
    powerup_timer_sel <= 2'h0;
    xtal <= 1'b1;
    run_case(0, 1'b0, 1'b0, 16'hc0fc, 16'h0003, 24'h000000, POR_CYC + MON_CYC, 2'h2);
    wdog_enable_clear();
    tally_and_finish();
  end
endmodule : rcwd_top_tb
